//--- pkg/irq_flags_pkg.sv
// package for the low-half interrupt status flag block
// assumes a 16-bit register port, word index addressing as printed below
package irq_flags_pkg;
    // ==========================================================
    // register map (word offsets of this block)
    localparam logic [3:0]  ADDR_STATUS       = 4'h0;
    localparam logic [3:0]  ADDR_MASK         = 4'h1;
    localparam logic [3:0]  ADDR_LOST         = 4'h2;
    localparam logic [3:0]  ADDR_TXPEND       = 4'h3;
    // ==========================================================
    // field positions in the status register
    localparam int          BIT_RESET_DONE    = 8;
    localparam int          BIT_WAKE          = 4;
    localparam int          BIT_OVERWRITE     = 1;
    localparam int          BIT_SLOT_FREE     = 0;
    // ==========================================================
    // reset values
    localparam logic [15:0] MASK_RESET        = 16'hFFFF;
    localparam logic [15:0] STATUS_RESET      = 16'h0100;
    localparam logic [15:0] ZERO16            = 16'h0000;
    // reset sequence length after power-on or standby, in clocks
    localparam logic [3:0]  RESET_SEQ_CYCLES  = 4'h8;
endpackage : irq_flags_pkg

//--- hw/flag_sticky.sv
// one sticky flag: hardware set wins over a write-1 clear
// assumes set and clear come from the same clock domain
module flag_sticky (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_rst_val,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);
    logic flag_reg;
    logic flag_next;

    // ==========================================================
    // next value: set beats clear, a zero write keeps the flag
    always_comb begin
        flag_next = flag_reg;
        if (i_clr) begin
            flag_next = 1'b0;
        end
        if (i_set) begin
            flag_next = 1'b1;
        end
    end

    // register; reset value is a constant per instance
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            flag_reg <= i_rst_val;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flag = flag_reg;
endmodule : flag_sticky

//--- hw/irq_status_low.sv
// low-half interrupt status flags with mask and request output
// assumes register strobes on i_clk; bus and standby inputs arrive from outside
// Overview of operation
// [RULE_01] reset-done flag is 1 after reset and cleared only by writing 1
// [RULE_02] reset-done flag requests an interrupt regardless of any mask bit
// [RULE_03] software should clear reset-done after reset or standby return
// [RULE_04] bits 7..5 and 3..2 read 0; software writes 0 there
// [RULE_05] dominant bit seen in sleep mode sets wake flag until written 1
// [RULE_06] overwrite flag is read only, set while any lost-message bit is set
// [RULE_07] overwrite flag clears only when all lost-message bits are clear
// [RULE_08] slot-free flag sets when a pending bit clears by completion or abort
// [RULE_09] slot-free flag tells software a mailbox may take the next message
// [RULE_10] other flags request only while their mask bit is 0; masks reset to 1
// [RULE_11] writing 0 leaves a flag alone; writing 1 only clears
module irq_status_low
    import irq_flags_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_standby,
    input  wire logic        i_sleep_mode,
    input  wire logic        i_bus_rx,
    input  wire logic [15:0] i_lost_set,
    input  wire logic [15:0] i_tx_request,
    input  wire logic [15:0] i_tx_done,
    input  wire logic [15:0] i_tx_abort_done,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_irq
);
    import irq_flags_pkg::*;

    logic [15:0] mask_reg,    mask_next;
    logic [15:0] lost_reg,    lost_next;
    logic [15:0] txpend_reg,  txpend_next;
    logic [15:0] rdata_reg,   rdata_next;
    logic        irq_reg,     irq_next;
    logic [3:0]  seq_cnt_reg, seq_cnt_next;
    logic        seq_busy_reg, seq_busy_next;
    logic        stby_q1_reg, stby_q2_reg;
    logic        rx_q1_reg,   rx_q2_reg;
    logic        slp_q1_reg,  slp_q2_reg;
    logic        seq_done;
    logic        reset_done_flag;
    logic        wake_bus_activity_flag;
    logic        tx_slot_free_flag;
    logic        message_overwrite_flag;
    logic        wr_status;
    logic [15:0] status_word;
    logic [15:0] pend_cleared;

    // address match, shared by write and read decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction : hit

    // ==========================================================
    // pin synchronisers: bus line, sleep level and standby come from outside
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            stby_q1_reg <= 1'b0;
            stby_q2_reg <= 1'b0;
            rx_q1_reg   <= 1'b1;
            rx_q2_reg   <= 1'b1;
            slp_q1_reg  <= 1'b0;
            slp_q2_reg  <= 1'b0;
        end else begin
            stby_q1_reg <= i_standby;
            stby_q2_reg <= stby_q1_reg;
            rx_q1_reg   <= i_bus_rx;
            rx_q2_reg   <= rx_q1_reg;
            slp_q1_reg  <= i_sleep_mode;
            slp_q2_reg  <= slp_q1_reg;
        end
    end

    // ==========================================================
    // reset sequence: runs after system reset and on leaving standby
    always_comb begin
        seq_cnt_next  = seq_cnt_reg;
        seq_busy_next = seq_busy_reg;
        if (stby_q2_reg) begin
            seq_busy_next = 1'b1;                   // hold while in standby
            seq_cnt_next  = 4'h0;
        end else if (seq_busy_reg) begin
            seq_cnt_next = seq_cnt_reg + 4'h1;
            if (seq_cnt_reg == RESET_SEQ_CYCLES - 4'h1) begin
                seq_busy_next = 1'b0;
            end
        end
    end
    assign seq_done = seq_busy_reg && !seq_busy_next;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            seq_cnt_reg  <= 4'h0;
            seq_busy_reg <= 1'b1;
        end else begin
            seq_cnt_reg  <= seq_cnt_next;
            seq_busy_reg <= seq_busy_next;
        end
    end

    // ==========================================================
    // writable flags: write 1 clears, hardware set wins on the same edge
    assign wr_status = i_wr && hit(i_addr, ADDR_STATUS);

    flag_sticky u_reset_done (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_rst_val (1'b1),                                         // [RULE_01]
        .i_set     (seq_done),                                     // [RULE_01]
        .i_clr     (wr_status && i_wdata[BIT_RESET_DONE]),         // [RULE_11]
        .o_flag    (reset_done_flag)
    );

    // a low bus level is dominant; only counted while asleep
    flag_sticky u_wake (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_rst_val (1'b0),
        .i_set     (slp_q2_reg && !rx_q2_reg),                     // [RULE_05]
        .i_clr     (wr_status && i_wdata[BIT_WAKE]),               // [RULE_11]
        .o_flag    (wake_bus_activity_flag)
    );

    flag_sticky u_slot_free (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_rst_val (1'b0),
        .i_set     (|pend_cleared),                                // [RULE_08] [RULE_09]
        .i_clr     (wr_status && i_wdata[BIT_SLOT_FREE]),          // [RULE_11]
        .o_flag    (tx_slot_free_flag)
    );

    // overwrite flag is pure status of the lost-message register
    assign message_overwrite_flag = |lost_reg;                     // [RULE_06] [RULE_07]

    // ==========================================================
    // per-mailbox pending and lost-message bits
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_box
            // completion only clears a bit that was actually pending
            assign pend_cleared[g] = txpend_reg[g] && (i_tx_done[g] || i_tx_abort_done[g]);
        end
    endgenerate

    always_comb begin
        mask_next   = mask_reg;
        lost_next   = lost_reg | i_lost_set;
        txpend_next = (txpend_reg & ~pend_cleared) | i_tx_request;
        if (i_wr && hit(i_addr, ADDR_MASK)) begin
            mask_next = i_wdata;
        end
        if (i_wr && hit(i_addr, ADDR_LOST)) begin
            lost_next = (lost_reg & ~i_wdata) | i_lost_set;         // set wins
        end
    end

    // ==========================================================
    // status word: reserved bits tied to zero
    always_comb begin
        status_word                 = ZERO16;                      // [RULE_04]
        status_word[BIT_RESET_DONE] = reset_done_flag;
        status_word[BIT_WAKE]       = wake_bus_activity_flag;
        status_word[BIT_OVERWRITE]  = message_overwrite_flag;
        status_word[BIT_SLOT_FREE]  = tx_slot_free_flag;
    end

    // read data and request, both registered
    always_comb begin
        rdata_next = ZERO16;
        if (i_rd) begin
            unique case (1'b1)
                hit(i_addr, ADDR_STATUS): rdata_next = status_word;
                hit(i_addr, ADDR_MASK):   rdata_next = mask_reg;
                hit(i_addr, ADDR_LOST):   rdata_next = lost_reg;
                hit(i_addr, ADDR_TXPEND): rdata_next = txpend_reg;
                default:                  rdata_next = ZERO16;     // unmapped reads 0
            endcase
        end
        irq_next = reset_done_flag                                 // [RULE_02]
                 | (wake_bus_activity_flag & ~mask_reg[BIT_WAKE])  // [RULE_10]
                 | (message_overwrite_flag & ~mask_reg[BIT_OVERWRITE])
                 | (tx_slot_free_flag & ~mask_reg[BIT_SLOT_FREE]);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mask_reg   <= MASK_RESET;                              // [RULE_10]
            lost_reg   <= ZERO16;
            txpend_reg <= ZERO16;
            rdata_reg  <= ZERO16;
            irq_reg    <= 1'b0;
        end else begin
            mask_reg   <= mask_next;
            lost_reg   <= lost_next;
            txpend_reg <= txpend_next;
            rdata_reg  <= rdata_next;
            irq_reg    <= irq_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq   = irq_reg;

    // ==========================================================
    // checks
    property p_reset_irq;
        @(posedge i_clk) disable iff (i_sys_rst)
        reset_done_flag |=> o_irq;
    endproperty
    a_reset_irq: assert property (p_reset_irq) else $error("reset flag did not request"); // [RULE_02]

    property p_reserved;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == ADDR_STATUS) |=> (o_rdata & 16'hFEEC) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // [RULE_04]

    property p_wake_set;
        @(posedge i_clk) disable iff (i_sys_rst)
        (slp_q2_reg && !rx_q2_reg) |=> wake_bus_activity_flag;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake flag not set"); // [RULE_05]

    property p_wake_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wake_bus_activity_flag && !(wr_status && i_wdata[BIT_WAKE])) |=> wake_bus_activity_flag;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake flag lost"); // [RULE_11]

    property p_ovw;
        @(posedge i_clk) disable iff (i_sys_rst)
        (|i_lost_set) |=> message_overwrite_flag;
    endproperty
    a_ovw: assert property (p_ovw) else $error("overwrite flag not set"); // [RULE_06]

    // only a write to the lost-message register may drop the flag; a status write may not
    property p_ovw_clear;
        @(posedge i_clk) disable iff (i_sys_rst)
        (message_overwrite_flag && !(i_wr && hit(i_addr, ADDR_LOST)))
            |=> message_overwrite_flag;
    endproperty
    a_ovw_clear: assert property (p_ovw_clear) else $error("overwrite flag dropped"); // [RULE_07]

    property p_slot;
        @(posedge i_clk) disable iff (i_sys_rst)
        (|pend_cleared) |=> tx_slot_free_flag;
    endproperty
    a_slot: assert property (p_slot) else $error("slot flag not set"); // [RULE_08]

    property p_mask;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!reset_done_flag && mask_reg == MASK_RESET) |=> !o_irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked flag requested"); // [RULE_10]

    property p_seq;
        @(posedge i_clk) disable iff (i_sys_rst)
        seq_done |=> reset_done_flag;
    endproperty
    a_seq: assert property (p_seq) else $error("reset flag not set after sequence"); // [RULE_01]
endmodule : irq_status_low

//--- verif/irq_ctrl_model.sv
// model of the processor interrupt controller on the request line
// assumes the same clock and sync reset as the flag block
module irq_ctrl_model (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_irq,
    input  wire logic i_enable,
    output logic      o_service
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // servicing
    // a request left standing is taken as soon as interrupts are enabled
    always_ff @(posedge i_clk) begin
        o_service <= !i_sys_rst && i_irq && i_enable;
    end
endmodule : irq_ctrl_model

//--- verif/can_irq_status_low_flags_tb_top.sv
// self-checking bench for the low-half interrupt status flags
// assumes the flag block package and a 50 MHz clock with sync reset
module can_irq_status_low_flags_tb_top import irq_flags_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } row_t;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_standby = 1'b0, i_sleep_mode = 1'b0;
    logic        i_bus_rx = 1'b1, i_wr = 1'b0, i_rd = 1'b0, irq_enable = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, i_lost_set = 16'h0000, i_tx_request = 16'h0000;
    logic [15:0] i_tx_done = 16'h0000, i_tx_abort_done = 16'h0000, o_rdata;
    logic        o_irq, service;
    int          err_total = 0, samples_checked = 0;
    // plain register accesses; mask rows keep unused bits at 1
    row_t        rows [5] = '{'{ADDR_MASK, 16'hFFEC, 16'hFFEC},
        '{ADDR_STATUS, 16'h0113, 16'h0000}, '{ADDR_TXPEND, 16'hFFFF, 16'h0000},
        '{ADDR_LOST, 16'hFFFF, 16'h0000}, '{4'hF, 16'hFFFF, 16'h0000}};
    // ==========================================================
    // clock, design and partner
    always #10 i_clk = ~i_clk;
    irq_status_low DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_standby(i_standby),
        .i_sleep_mode(i_sleep_mode), .i_bus_rx(i_bus_rx), .i_lost_set(i_lost_set),
        .i_tx_request(i_tx_request), .i_tx_done(i_tx_done),
        .i_tx_abort_done(i_tx_abort_done), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
    irq_ctrl_model ctrl_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq(o_irq),
        .i_enable(irq_enable), .o_service(service));
    // ==========================================================
    // tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so look mid-cycle
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk(o_rdata, exp);
        @(posedge i_clk);
    endtask : rd
    // one-cycle event pulse: 0 lost, 1 request, 2 done, 3 abort done
    task automatic ev(input int k, input logic [15:0] v);
        case (k)
            0: i_lost_set <= v;
            1: i_tx_request <= v;
            2: i_tx_done <= v;
            default: i_tx_abort_done <= v;
        endcase
        @(posedge i_clk);
        {i_lost_set, i_tx_request, i_tx_done, i_tx_abort_done} <= 64'h0;
        tick(2);
    endtask : ev
    // bounded wait on the request line; running out ends the run
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        @(negedge i_clk);
        while (o_irq !== exp && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        chk({15'h0000, o_irq}, {15'h0000, exp});
        if (o_irq !== exp) final_report();
        @(posedge i_clk);
    endtask : wait_irq
    // ==========================================================
    // watchdog: a hang counts as a mismatch
    initial begin
        #100us;
        err_total++;
        final_report();
    end
    // ==========================================================
    // main sequence
    initial begin
        tick(16);
        i_sys_rst <= 1'b0;
        tick(12);
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_MASK, MASK_RESET);
        wait_irq(1'b1);
        irq_enable <= 1'b1;
        tick(2);
        @(negedge i_clk);
        chk({15'h0000, service}, 16'h0001);
        @(posedge i_clk);
        wr(ADDR_STATUS, 16'h0000);
        rd(ADDR_STATUS, STATUS_RESET);
        wr(ADDR_STATUS, 16'h0100);
        wait_irq(1'b0);
        rd(ADDR_STATUS, ZERO16);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].exp);
        end
        wr(ADDR_MASK, MASK_RESET);
        // completion with nothing pending must not free a slot
        ev(2, 16'h0080);
        rd(ADDR_STATUS, ZERO16);
        ev(1, 16'h0008);
        rd(ADDR_TXPEND, 16'h0008);
        ev(2, 16'h0008);
        rd(ADDR_TXPEND, ZERO16);
        rd(ADDR_STATUS, 16'h0001);
        wait_irq(1'b0);
        wr(ADDR_MASK, 16'hFFFE);
        wait_irq(1'b1);
        wr(ADDR_STATUS, 16'h0001);
        wait_irq(1'b0);
        ev(1, 16'h0020);
        ev(3, 16'h0020);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        // completion and write-1 clear on one edge: the set wins
        ev(1, 16'h0001);
        i_tx_done <= 16'h0001;
        wr(ADDR_STATUS, 16'h0001);
        i_tx_done <= 16'h0000;
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, ZERO16);
        wr(ADDR_MASK, MASK_RESET);
        // overwrite flag follows the lost-message bits only
        ev(0, 16'h0204);
        rd(ADDR_LOST, 16'h0204);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_STATUS, 16'h0002);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_LOST, 16'h0004);
        tick(2);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_LOST, 16'h0200);
        tick(2);
        rd(ADDR_STATUS, ZERO16);
        // dominant bit outside sleep is ignored, inside sleep it sticks
        i_bus_rx <= 1'b0;
        tick(6);
        i_bus_rx <= 1'b1;
        tick(4);
        rd(ADDR_STATUS, ZERO16);
        i_sleep_mode <= 1'b1;
        tick(4);
        i_bus_rx <= 1'b0;
        tick(6);
        i_bus_rx <= 1'b1;
        tick(6);
        rd(ADDR_STATUS, 16'h0010);
        wr(ADDR_MASK, 16'hFFEF);
        wait_irq(1'b1);
        wr(ADDR_STATUS, 16'h0010);
        wait_irq(1'b0);
        rd(ADDR_STATUS, ZERO16);
        wr(ADDR_MASK, MASK_RESET);
        i_sleep_mode <= 1'b0;
        // leaving standby reruns the reset sequence
        i_standby <= 1'b1;
        tick(4);
        i_standby <= 1'b0;
        wait_irq(1'b1);
        rd(ADDR_STATUS, STATUS_RESET);
        // mid-run reset brings back the power-on values
        wr(ADDR_MASK, 16'hFFEC);
        i_sys_rst <= 1'b1;
        tick(3);
        @(negedge i_clk);
        chk({15'h0000, o_irq}, 16'h0000);
        chk(o_rdata, ZERO16);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(ADDR_MASK, MASK_RESET);
        wait_irq(1'b1);
        rd(ADDR_STATUS, STATUS_RESET);
        final_report();
    end
endmodule : can_irq_status_low_flags_tb_top
